// ### rtl/qdsw_pkg.sv
// Shared constants of the switch delay block and its host port.
// Assumes one 10 MHz clock shared by both ends of the port.
package qdsw_pkg;
  // ----------------------------------------
  // Port geometry
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CH_N = 32;
  localparam int CH_W = 5;
  localparam int BANKS = 3;
  localparam int STREAMS = 2;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [13:0] CTRL_OFF = 14'h0000;
  localparam logic [13:0] TALLY_OFF = 14'h0001;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] TALLY_RESET = 16'h0000;
  localparam int FILL_MSB = 15;
  localparam int FILL_LSB = 13;
  localparam int UNUSED_HI_BIT = 12;
  localparam int CLK_SEL_BIT = 11;
  localparam int ERR_CLR_BIT = 10;
  localparam int ERR_START_BIT = 9;
  localparam int FEVAL_BIT = 8;
  localparam int UNUSED_LO_BIT = 7;
  localparam int GO_BIT = 6;
  localparam int ARM_BIT = 5;
  localparam int MEM_SEL_BIT = 4;
  localparam int STANDBY_BIT = 3;
  // ----------------------------------------
  // Memory window decode
  // ----------------------------------------
  localparam int MEM_WIN_BIT = 13;
  localparam int DM_WIN_BIT = 12;
  localparam int STREAM_BIT = 5;
  localparam int TYPE_HI_BIT = 15;
  localparam int TYPE_LO_BIT = 14;
  localparam int VAR_LEAD = 3;
  localparam int FILL_FRAMES = 2;
  // ----------------------------------------
  // Channel timing, cycles of I_CLK
  // ----------------------------------------
  localparam int CLK_NS = 100;
  localparam int CH_NS_FAST = 400;
  localparam int CH_CYC_FAST = (CH_NS_FAST + CLK_NS - 1) / CLK_NS;
  localparam int CH_CYC_SLOW = 2 * CH_CYC_FAST;
endpackage : qdsw_pkg

// ### rtl/qdsw_if.sv
// Non-multiplexed host port between the switch and its host.
// Both ends run on the same clock; the data bus level is resolved here.
`timescale 1ns/1ps
interface qdsw_if;
  logic cs_n;
  logic data_strobe_n;
  logic rd_wr;
  logic [13:0] host_addr_bus;
  logic [15:0] host_wr_data;
  logic host_wr_oe;
  logic [15:0] dev_rd_data;
  logic dev_rd_oe;
  logic transfer_ack_n;
  logic [15:0] host_data_bus;
  // Device wins while it drives; otherwise the host's value stands
  assign host_data_bus = dev_rd_oe ? dev_rd_data : host_wr_data;
  modport device (input cs_n, data_strobe_n, rd_wr, host_addr_bus, host_data_bus,
    output dev_rd_data, dev_rd_oe, transfer_ack_n);
  modport host (output cs_n, data_strobe_n, rd_wr, host_addr_bus, host_wr_data,
    host_wr_oe, input host_data_bus, transfer_ack_n);
endinterface : qdsw_if

// ### rtl/qdsw_fifo.sv
// Flop-based FIFO in the serial input path.
// Assumes the drain side may stall for many cycles.
`timescale 1ns/1ps
module qdsw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  output logic [WIDTH-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW:0] next_count;
  logic push;
  logic pop;
  assign push = i_wr_valid && o_wr_ready;
  assign pop = o_rd_valid && i_rd_ready;
  assign o_rd_valid = (count != '0);
  assign o_rd_data = mem[rd_ptr];
  // Ready is a flop so a full FIFO refuses the very next beat
  assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= i_wr_data;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_wr_ready <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      o_wr_ready <= (next_count != (PW+1)'(DEPTH));
    end
  end
endmodule : qdsw_fifo

// ### rtl/qdsw_device.sv
// Switch end: delay selection per channel and the host port slave.
// Assumes the host keeps its own port rules; input bytes arrive via a FIFO.
// Behaviour
// RULE1: connection entries select delay type per channel
// RULE2: variable delay depends on channel numbers only
// RULE3: variable delay three channels to frame+three; the code's delay runs from 3 to at most 34 channels (frame+two)
// RULE4: variable delay only on odd output stream
// RULE5: host avoids variable type on even streams
// RULE6: constant delay is exactly two frames, buffered
// RULE7: constant delay on every output stream
// RULE8: separate address and data lines
// RULE9: 16 data, 14 address, four control lines
// RULE10: registers and connection memory read and write
// RULE11: data memory and tally are read only
// RULE12: host reads data memory twice, same address
// RULE13: host discards first data memory read
// RULE14: control at address zero, resets zero
// RULE15: control register field layout
// RULE16: fill copies value into entry bits 15..13
// RULE17: fill clears entry bits 12..0
// RULE18: host writes control bit 12 zero
// RULE19: clock select bit sets channel rate
// RULE20: fill takes two frames, go self-clears
// RULE21: fill acts only while arm bit set
`timescale 1ns/1ps
module qdsw_device
  import qdsw_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  qdsw_if.device bus,
  input wire logic [7:0] I_RX_BYTE,
  input wire logic I_RX_VALID,
  output logic O_RX_READY,
  output logic [7:0] O_TX_EVEN,
  output logic [7:0] O_TX_ODD,
  output logic O_FRAME
);
  typedef enum logic [2:0] {
    FILL_IDLE = 3'b001,
    FILL_RUN = 3'b010,
    FILL_WAIT = 3'b100
  } qdsw_fill_t;
  localparam int CM_N = STREAMS * CH_N;
  localparam int CM_W = $clog2(CM_N);
  localparam int DM_N = BANKS * CH_N;
  localparam int DM_W = $clog2(DM_N);
  logic [15:0] ctrl;
  logic [15:0] tally;
  logic [15:0] cm [CM_N];
  logic [7:0] dm [DM_N];
  logic [15:0] dm_hold;
  logic [3:0] cyc;
  logic ch_tick;
  logic [CH_W-1:0] ch;
  logic [1:0] bank;
  logic frame_end;
  logic access;
  logic act;
  logic go_prev;
  qdsw_fill_t fill_state;
  logic [CM_W-1:0] fill_idx;
  logic [1:0] fill_frames;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_ready;
  logic [13:0] addr;
  logic [7:0] tx [STREAMS];

  function automatic logic [1:0] bank_back(input logic [1:0] b, input int n);
    logic [2:0] t;
    t = {1'b0, b} + 3'(BANKS) - 3'(n);
    return (t >= 3'(BANKS)) ? 2'(t - 3'(BANKS)) : t[1:0];
  endfunction : bank_back

  function automatic logic [DM_W-1:0] dm_at(input logic [1:0] b, input logic [CH_W-1:0] c);
    return DM_W'(b * CH_N) + DM_W'(c);
  endfunction : dm_at

  // ----------------------------------------
  // Input FIFO
  // ----------------------------------------
  qdsw_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_wr_data(I_RX_BYTE),
    .i_wr_valid(I_RX_VALID),
    .o_wr_ready(rx_ready),
    .o_rd_data(rx_data),
    .o_rd_valid(rx_valid),
    .i_rd_ready(ch_tick)
  );
  assign O_RX_READY = rx_ready;

  // ----------------------------------------
  // Channel and frame timing
  // ----------------------------------------
  // RULE19: rate from select
  assign ch_tick = (cyc == (ctrl[CLK_SEL_BIT] ? 4'(CH_CYC_SLOW - 1) : 4'(CH_CYC_FAST - 1)));
  assign frame_end = ch_tick && (ch == CH_W'(CH_N - 1));
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      cyc <= 4'h0;
      ch <= '0;
      bank <= 2'h0;
      O_FRAME <= 1'b0;
    end
    else
    begin
      cyc <= ch_tick ? 4'h0 : cyc + 4'h1;
      O_FRAME <= frame_end;
      if (ch_tick)
      begin
        ch <= ch + 1'b1;
      end
      if (frame_end)
      begin
        bank <= (bank == 2'(BANKS - 1)) ? 2'h0 : bank + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Data memory, three frame banks
  // ----------------------------------------
  // RULE6: triple buffer
  always_ff @(posedge I_CLK)
  begin
    if (ch_tick)
    begin
      dm[dm_at(bank, ch)] <= rx_valid ? rx_data : 8'h00;
    end
  end

  // ----------------------------------------
  // Output streams
  // ----------------------------------------
  for (genvar s = 0; s < STREAMS; s++)
  begin : g_out
    logic [15:0] ent;
    logic [CH_W-1:0] src;
    logic var_mode;
    logic [1:0] rd_bank;
    assign ent = cm[CM_W'(s * CH_N) + CM_W'(ch)];
    assign src = ent[CH_W-1:0];
    // RULE1: type per entry
    // RULE4: odd stream only
    assign var_mode = !ent[TYPE_HI_BIT] && !ent[TYPE_LO_BIT] && (s % 2 == 1);
    // RULE2: channel numbers only
    // RULE3: three channel lead
    // RULE7: constant on all
    always_comb
    begin
      if (var_mode)
      begin
        if ({1'b0, src} + 6'(VAR_LEAD) <= {1'b0, ch})
        begin
          rd_bank = bank;
        end
        else if ({1'b0, src} <= {1'b0, ch} + 6'(CH_N - VAR_LEAD))
        begin
          rd_bank = bank_back(bank, 1);
        end
        else
        begin
          // Late sources would come out too soon, so take the older bank
          rd_bank = bank_back(bank, 2);
        end
      end
      else
      begin
        rd_bank = bank_back(bank, FILL_FRAMES);
      end
    end
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
      if (!I_RST_N)
      begin
        tx[s] <= 8'h00;
      end
      else if (ch_tick)
      begin
        tx[s] <= ctrl[STANDBY_BIT] ? 8'h00 : dm[dm_at(rd_bank, src)];
      end
    end
  end
  assign O_TX_EVEN = tx[0];
  assign O_TX_ODD = tx[1];

  // ----------------------------------------
  // Host port handshake
  // ----------------------------------------
  // RULE8: separate lines
  // RULE9: four control lines
  assign access = !bus.cs_n && !bus.data_strobe_n;
  assign act = access && bus.transfer_ack_n;
  assign addr = bus.host_addr_bus;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      bus.transfer_ack_n <= 1'b1;
      bus.dev_rd_oe <= 1'b0;
    end
    else
    begin
      bus.transfer_ack_n <= !access;
      bus.dev_rd_oe <= access && bus.rd_wr;
    end
  end

  // RULE10: readable locations
  // RULE13: read returns previous hold
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      bus.dev_rd_data <= 16'h0000;
      dm_hold <= 16'h0000;
    end
    else if (act && bus.rd_wr)
    begin
      if (addr[MEM_WIN_BIT] && addr[DM_WIN_BIT])
      begin
        bus.dev_rd_data <= dm_hold;
        dm_hold <= {8'h00, dm[dm_at(bank_back(bank, 1), addr[CH_W-1:0])]};
      end
      else if (addr[MEM_WIN_BIT])
      begin
        bus.dev_rd_data <= cm[addr[CM_W-1:0]];
      end
      else if (addr == CTRL_OFF)
      begin
        bus.dev_rd_data <= ctrl;
      end
      else if (addr == TALLY_OFF)
      begin
        bus.dev_rd_data <= tally;
      end
      else
      begin
        bus.dev_rd_data <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // Control and tally registers
  // ----------------------------------------
  // RULE14: zero at reset
  // RULE15: stored as laid out
  // RULE20: go self-clears
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      ctrl <= CTRL_RESET;
      go_prev <= 1'b0;
    end
    else
    begin
      go_prev <= ctrl[GO_BIT];
      if (act && !bus.rd_wr && addr == CTRL_OFF)
      begin
        ctrl <= bus.host_data_bus;
      end
      else if (fill_state == FILL_WAIT && fill_frames == 2'(FILL_FRAMES))
      begin
        ctrl[GO_BIT] <= 1'b0;
      end
    end
  end

  // RULE11: tally writes ignored
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      tally <= TALLY_RESET;
    end
    else if (ctrl[ERR_CLR_BIT])
    begin
      tally <= TALLY_RESET;
    end
  end

  // ----------------------------------------
  // Block fill of connection memory
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      fill_state <= FILL_IDLE;
      fill_idx <= '0;
      fill_frames <= 2'h0;
    end
    else
    begin
      if (frame_end && fill_state != FILL_IDLE)
      begin
        fill_frames <= fill_frames + 2'h1;
      end
      case (fill_state)
        FILL_IDLE:
        begin
          fill_idx <= '0;
          fill_frames <= 2'h0;
          if (ctrl[GO_BIT] && !go_prev && ctrl[ARM_BIT])
          begin
            fill_state <= FILL_RUN;
          end
        end
        FILL_RUN:
        begin
          fill_idx <= fill_idx + 1'b1;
          if (fill_idx == CM_W'(CM_N - 1))
          begin
            fill_state <= FILL_WAIT;
          end
        end
        FILL_WAIT:
        begin
          if (fill_frames == 2'(FILL_FRAMES))
          begin
            fill_state <= FILL_IDLE;
          end
        end
        default:
        begin
          fill_state <= FILL_IDLE;
        end
      endcase
      // RULE21: abort when disarmed
      if (!ctrl[GO_BIT] || !ctrl[ARM_BIT])
      begin
        fill_state <= FILL_IDLE;
      end
    end
  end

  // Fill owns the memory while it runs, so host writes then are dropped
  always_ff @(posedge I_CLK)
  begin
    if (fill_state == FILL_RUN)
    begin
      // RULE16: copy fill value
      // RULE17: clear low bits
      cm[fill_idx] <= {ctrl[FILL_MSB:FILL_LSB], 13'h0000};
    end
    else if (act && !bus.rd_wr && addr[MEM_WIN_BIT] && !addr[DM_WIN_BIT])
    begin
      cm[addr[CM_W-1:0]] <= bus.host_data_bus;
    end
  end
endmodule : qdsw_device

// ### rtl/qdsw_host.sv
// Host end of the port: runs one access per user request, two for a data memory read.
// Assumes the switch answers each strobe with an acknowledge.
`timescale 1ns/1ps
module qdsw_host
  import qdsw_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  qdsw_if.host bus,
  input wire logic I_REQ,
  input wire logic I_WRITE,
  input wire logic [13:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic O_READY,
  output logic O_DONE,
  output logic [15:0] O_RDATA
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_STROBE = 3'b010,
    H_RELEASE = 3'b100
  } qdsw_hstate_t;
  qdsw_hstate_t state;
  logic twice;
  logic second;
  logic [15:0] wdata;

  // ----------------------------------------
  // Write data screening
  // ----------------------------------------
  always_comb
  begin
    wdata = I_WDATA;
    if (I_ADDR == CTRL_OFF)
    begin
      // RULE18: unused bit zero
      wdata[UNUSED_HI_BIT] = 1'b0;
      wdata[UNUSED_LO_BIT] = 1'b0;
    end
    // RULE5: even stream forced constant
    if (I_ADDR[MEM_WIN_BIT] && !I_ADDR[DM_WIN_BIT] && !I_ADDR[STREAM_BIT]
        && !I_WDATA[TYPE_HI_BIT] && !I_WDATA[TYPE_LO_BIT])
    begin
      wdata[TYPE_HI_BIT] = 1'b1;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state <= H_IDLE;
      twice <= 1'b0;
      second <= 1'b0;
      O_READY <= 1'b1;
      O_DONE <= 1'b0;
      O_RDATA <= 16'h0000;
      bus.cs_n <= 1'b1;
      bus.data_strobe_n <= 1'b1;
      bus.rd_wr <= 1'b1;
      bus.host_addr_bus <= 14'h0000;
      bus.host_wr_data <= 16'h0000;
      bus.host_wr_oe <= 1'b0;
    end
    else
    begin
      O_DONE <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (I_REQ)
          begin
            // RULE12: data memory read twice
            twice <= !I_WRITE && I_ADDR[MEM_WIN_BIT] && I_ADDR[DM_WIN_BIT];
            second <= 1'b0;
            O_READY <= 1'b0;
            bus.cs_n <= 1'b0;
            bus.data_strobe_n <= 1'b0;
            bus.rd_wr <= !I_WRITE;
            bus.host_addr_bus <= I_ADDR;
            bus.host_wr_data <= wdata;
            bus.host_wr_oe <= I_WRITE;
            state <= H_STROBE;
          end
        end
        H_STROBE:
        begin
          if (!bus.transfer_ack_n)
          begin
            // RULE13: keep only second value
            if (bus.rd_wr && (!twice || second))
            begin
              O_RDATA <= bus.host_data_bus;
            end
            bus.cs_n <= 1'b1;
            bus.data_strobe_n <= 1'b1;
            bus.host_wr_oe <= 1'b0;
            state <= H_RELEASE;
          end
        end
        H_RELEASE:
        begin
          if (bus.transfer_ack_n)
          begin
            if (twice && !second)
            begin
              second <= 1'b1;
              bus.cs_n <= 1'b0;
              bus.data_strobe_n <= 1'b0;
              state <= H_STROBE;
            end
            else
            begin
              O_DONE <= 1'b1;
              O_READY <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end
endmodule : qdsw_host

// ### tb/qdsw_asserts.sv
// Checker for the host port between the host end and the switch end.
// Assumes plain interface signals and one shared clock.
`timescale 1ns/1ps
module qdsw_asserts
  import qdsw_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic cs_n,
  input wire logic data_strobe_n,
  input wire logic rd_wr,
  input wire logic [13:0] host_addr_bus,
  input wire logic [15:0] host_wr_data,
  input wire logic host_wr_oe,
  input wire logic [15:0] dev_rd_data,
  input wire logic dev_rd_oe,
  input wire logic transfer_ack_n,
  input wire logic [15:0] host_data_bus
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_N);
  // ----
  // Helper state
  // ----
  logic act;
  logic rd_ack;
  logic ctl_wr;
  logic [15:0] shadow;
  logic [9:0] age;
  assign act = !cs_n && !data_strobe_n && transfer_ack_n;
  assign rd_ack = !transfer_ack_n && !data_strobe_n && !cs_n && rd_wr;
  assign ctl_wr = act && !rd_wr && host_addr_bus == CTRL_OFF;
  // Age saturates, so a fill's end is judged only long after two frames
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      shadow <= CTRL_RESET;
      age <= 10'h3ff;
    end
    else if (ctl_wr)
    begin
      shadow <= host_data_bus;
      age <= 10'h000;
    end
    else if (age != 10'h3ff)
      age <= age + 10'h001;
  end
  // ----
  // Port properties
  // ----
  // ack answers strobe
  property p_ack_follows; act |=> !transfer_ack_n; endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("no acknowledge after strobe");
  property p_ack_cause;
    $fell(transfer_ack_n) |-> !$past(cs_n) && !$past(data_strobe_n);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("acknowledge without strobe");
  property p_ack_release; $rose(data_strobe_n) |-> ##[0:2] transfer_ack_n; endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("acknowledge held too long");
  property p_rd_drive; rd_ack |-> dev_rd_oe && host_data_bus == dev_rd_data; endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not on bus");
  property p_no_fight; (!transfer_ack_n && !rd_wr) |-> !dev_rd_oe; endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("device drives during write");
  property p_ctrl_back;
    rd_ack && host_addr_bus == CTRL_OFF |-> (dev_rd_data & 16'hffbf) == (shadow & 16'hffbf);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back)
    else $error("control readback differs");
  property p_tally; rd_ack && host_addr_bus == TALLY_OFF |-> dev_rd_data == TALLY_RESET; endproperty
  a_tally: assert property (p_tally)
    else $error("tally not zero");
  property p_fill_busy;
    rd_ack && host_addr_bus == CTRL_OFF && age < 10'h064 && shadow[ARM_BIT] && shadow[GO_BIT]
      |-> dev_rd_data[GO_BIT];
  endproperty
  a_fill_busy: assert property (p_fill_busy)
    else $error("fill ended too early");
  property p_fill_done;
    rd_ack && host_addr_bus == CTRL_OFF && age == 10'h3ff && shadow[ARM_BIT]
      |-> !dev_rd_data[GO_BIT];
  endproperty
  a_fill_done: assert property (p_fill_done)
    else $error("fill never finished");
  c_ctl_write: cover property (ctl_wr);
  c_dm_read: cover property (rd_ack && host_addr_bus[DM_WIN_BIT] && host_addr_bus[MEM_WIN_BIT]);
  c_fill_seen: cover property (rd_ack && host_addr_bus == CTRL_OFF && age == 10'h3ff);
endmodule : qdsw_asserts

// ### tb/test_switch_delay_and_host_port.sv
// Bench: host end and switch end joined by the port.
// Assumes a 10 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
module test_switch_delay_and_host_port
  import qdsw_pkg::*;
;
  // ----
  // Ends and checker
  // ----
  logic I_CLK;
  logic I_RST_N;
  logic req, wr, ready, done, rx_valid, rx_ready, frame;
  logic [13:0] addr;
  logic [15:0] wdata, rdata;
  logic [7:0] rx_byte, tx_even, tx_odd;
  logic [31:0] note;
  logic [31:0] notes[$];
  int n_mismatch = 0;
  int n_compared = 0;
  qdsw_if bus_if ();
  qdsw_device qdsw_device_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .bus(bus_if.device),
    .I_RX_BYTE(rx_byte), .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready),
    .O_TX_EVEN(tx_even), .O_TX_ODD(tx_odd), .O_FRAME(frame));
  qdsw_host qdsw_host_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .bus(bus_if.host),
    .I_REQ(req), .I_WRITE(wr), .I_ADDR(addr), .I_WDATA(wdata), .O_READY(ready),
    .O_DONE(done), .O_RDATA(rdata));
  qdsw_asserts qdsw_asserts_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .cs_n(bus_if.cs_n),
    .data_strobe_n(bus_if.data_strobe_n), .rd_wr(bus_if.rd_wr),
    .host_addr_bus(bus_if.host_addr_bus), .host_wr_data(bus_if.host_wr_data),
    .host_wr_oe(bus_if.host_wr_oe), .dev_rd_data(bus_if.dev_rd_data),
    .dev_rd_oe(bus_if.dev_rd_oe), .transfer_ack_n(bus_if.transfer_ack_n),
    .host_data_bus(bus_if.host_data_bus));
  initial
  begin
    I_CLK = 1'b0;
    forever #50 I_CLK = ~I_CLK;
  end
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_ready();
    for (int k = 0; k < 100 && ready !== 1'b1; k++)
      @(negedge I_CLK);
  endtask : wait_ready
  // Expected value is noted before the request; with mask zero the check still runs and compares zero to the expected value
  task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d,
    input logic [15:0] m, input logic [15:0] e);
    wait_ready();
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = d;
    notes.push_back({m, e});
    @(negedge I_CLK);
    req = 1'b0;
    wait_ready();
  endtask : access
  task automatic frame_gap(output int n);
    for (int k = 0; k < 600 && frame !== 1'b1; k++)
      @(negedge I_CLK);
    n = 0;
    do
    begin
      @(negedge I_CLK);
      n++;
    end
    while (frame !== 1'b1 && n < 600);
  endtask : frame_gap
  task automatic wait_tx(input logic odd, input logic [7:0] v, output int n);
    for (n = 0; n < 1000 && (odd ? tx_odd : tx_even) !== v; n++)
      @(negedge I_CLK);
  endtask : wait_tx
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  always @(negedge I_CLK)
  begin
    if (done === 1'b1)
    begin
      note = (notes.size() > 0) ? notes.pop_front() : 32'hffff_ffff;
      check(rdata & note[31:16], note[15:0]);
    end
  end
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    n_mismatch++;
    conclude();
  end
  // ----
  // Scenarios
  // ----
  initial
  begin : main
    int gap, n1, n2;
    logic [15:0] v;
    logic [13:0] a;
    logic [7:0] b;
    logic [2:0] fills[2] = '{3'b101, 3'b000};
    {I_RST_N, req, wr, rx_valid, addr, wdata, rx_byte} = '0;
    void'($urandom(32'h1d98));
    repeat (6) @(negedge I_CLK);
    I_RST_N = 1'b1;
    access(1'b0, CTRL_OFF, 16'h0000, 16'hffff, CTRL_RESET);
    access(1'b1, TALLY_OFF, 16'hffff, 16'h0000, 16'h0000);
    access(1'b0, TALLY_OFF, 16'h0000, 16'hffff, TALLY_RESET);
    access(1'b0, 14'h0123, 16'h0000, 16'hffff, 16'h0000);
    repeat (4)
    begin
      v = 16'($urandom) & 16'hef1f;
      access(1'b1, CTRL_OFF, v, 16'h0000, 16'h0000);
      access(1'b0, CTRL_OFF, 16'h0000, 16'hffff, v);
      a = 14'h2000 | 14'($urandom_range(63));
      v = {2'b10, 9'h000, 5'($urandom)};
      access(1'b1, a, v, 16'h0000, 16'h0000);
      access(1'b0, a, 16'h0000, 16'hffff, v);
    end
    access(1'b1, CTRL_OFF, 16'h1080, 16'h0000, 16'h0000);
    access(1'b0, CTRL_OFF, 16'h0000, 16'hffff, 16'h0000);
    a = 14'h2000 | 14'($urandom_range(31));
    access(1'b1, a, 16'h0003, 16'h0000, 16'h0000);
    access(1'b0, a, 16'h0000, 16'hc000, 16'h8000);
    // serial fill, buffer full, double read
    b = 8'($urandom);
    rx_byte = b;
    rx_valid = 1'b1;
    repeat (40) @(negedge I_CLK);
    // Full buffer takes one byte per channel tick: two in eight cycles
    n1 = 0;
    repeat (8)
    begin
      @(negedge I_CLK);
      n1 += (rx_ready === 1'b1) ? 1 : 0;
    end
    check(16'(n1), 16'h0002);
    repeat (520) @(negedge I_CLK);
    a = 14'h3000 | 14'($urandom_range(31));
    access(1'b0, a, 16'h0000, 16'h00ff, {8'h00, b});
    access(1'b1, a, {8'h00, ~b}, 16'h0000, 16'h0000);
    access(1'b0, a, 16'h0000, 16'h00ff, {8'h00, b});
    foreach (fills[i])
    begin
      v = {fills[i], 13'h0000};
      access(1'b1, CTRL_OFF, v | 16'h0060, 16'h0000, 16'h0000);
      access(1'b0, CTRL_OFF, 16'h0000, 16'h0040, 16'h0040);
      for (int k = 0; k < 100 && rdata[GO_BIT] !== 1'b0; k++)
        access(1'b0, CTRL_OFF, 16'h0000, 16'h0000, 16'h0000);
      access(1'b0, CTRL_OFF, 16'h0000, 16'hffff, v | 16'h0020);
      access(1'b0, 14'h2000 | 14'($urandom_range(63)), 16'h0000, 16'hffff, v);
    end
    repeat (300) @(negedge I_CLK);
    check({8'h00, tx_even}, {8'h00, b});
    rx_byte = ~b;
    wait_tx(1'b1, ~b, n1);
    wait_tx(1'b0, ~b, n2);
    check({15'h0000, n1 >= 12 && n1 < 256}, 16'h0001);
    check({15'h0000, n1 + n2 >= 256 && n1 + n2 <= 460}, 16'h0001);
    frame_gap(gap);
    check(16'(gap), 16'(32 * CH_CYC_FAST));
    access(1'b1, CTRL_OFF, 16'h0800, 16'h0000, 16'h0000);
    frame_gap(gap);
    frame_gap(gap);
    check(16'(gap), 16'(32 * CH_CYC_SLOW));
    rx_valid = 1'b0;
    repeat (150) @(negedge I_CLK);
    check({15'h0000, rx_ready}, 16'h0001);
    // Slow-rate fill, read back long after it must have ended
    access(1'b1, CTRL_OFF, 16'h0860, 16'h0000, 16'h0000);
    repeat (1100) @(negedge I_CLK);
    access(1'b0, CTRL_OFF, 16'h0000, 16'hffff, 16'h0820);
    conclude();
  end
endmodule : test_switch_delay_and_host_port
